// File: ebpwm_core.sv
/*
 holds the enhanced compare and bridge pwm unit with its register port.
 assumes a same-clock register master, q clock rate equal to clock, and that software
 sets the pin direction bits itself.
*/
// Implementation choices: strobed register access and the register offsets.
`include "ebpwm_defines.svh"

module ebpwm_core (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [15:0] timer_one_count,
    input wire logic [15:0] timer_three_count,
    output logic timer_one_reset,
    output logic timer_three_reset,
    output logic single_compare_out,
    output logic bridge_out_a,
    output logic bridge_out_b,
    output logic bridge_out_c,
    output logic bridge_out_d,
    output logic [3:0] pin_owned
);
    import ebpwm_pkg::*;

    // ----------------------------------------
    // software registers
    // ----------------------------------------
    logic [7:0] unit_control_reg_ff;
    logic [7:0] duty_low_byte_ff;
    logic [7:0] duty_shadow_byte_ff;
    logic [7:0] period_limit_reg_ff;
    logic [7:0] deadband_delay_reg_ff;
    logic [1:0] prescale_sel_ff;
    logic [15:0] cmp_value_ff;
    logic timer_sel_ff;
    logic [7:0] period_timer_count_ff;
    logic [1:0] shadow_low_ff;
    logic [3:0] act_mode_ff;
    logic [1:0] act_cfg_ff;
    logic [6:0] act_delay_ff;
    logic [1:0] act_pre_ff;
    logic [1:0] q_ff;
    logic [3:0] pre_cnt_ff;
    logic running_ff;
    logic pwm_ff;
    logic duty_done_ff;
    logic cmp_hit_ff;

    logic pwm_mode;
    logic inc_tick;
    logic period_match;
    logic duty_match;
    logic [3:0] pre_last;
    logic [1:0] sub_bits;
    logic step_end;
    logic [10:0] pos_next;
    logic [6:0] nxt_delay;

    function automatic logic [3:0] pre_limit(input logic [1:0] sel);
        unique case (sel)
            2'h0: pre_limit = 4'h0;
            2'h1: pre_limit = 4'h3;
            default: pre_limit = 4'hf;
        endcase
    endfunction : pre_limit

    assign pwm_mode = (act_mode_ff[3:2] == 2'h3);

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            unit_control_reg_ff <= `EBPWM_RST_CTRL;
            duty_low_byte_ff <= `EBPWM_RST_BYTE;
            period_limit_reg_ff <= `EBPWM_RST_PERIOD;
            deadband_delay_reg_ff <= `EBPWM_RST_BYTE;
            prescale_sel_ff <= 2'h0;
            cmp_value_ff <= 16'h0000;
            timer_sel_ff <= 1'b0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                `EBPWM_ADDR_CTRL: unit_control_reg_ff <= reg_wdata;
                `EBPWM_ADDR_DUTY_LO: duty_low_byte_ff <= reg_wdata;
                `EBPWM_ADDR_PERIOD: period_limit_reg_ff <= reg_wdata;
                `EBPWM_ADDR_DEADBAND: deadband_delay_reg_ff <= reg_wdata;
                `EBPWM_ADDR_PRESCALE: prescale_sel_ff <= reg_wdata[1:0];
                `EBPWM_ADDR_CMP_LO: cmp_value_ff[7:0] <= reg_wdata;
                `EBPWM_ADDR_CMP_HI: cmp_value_ff[15:8] <= reg_wdata;
                `EBPWM_ADDR_TSEL: timer_sel_ff <= reg_wdata[0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // shadow byte, writable only outside pwm mode
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            duty_shadow_byte_ff <= `EBPWM_RST_BYTE;
            shadow_low_ff <= 2'h0;
        end else if ((unit_control_reg_ff[3:2] == 2'h3) && period_match && inc_tick) begin
            duty_shadow_byte_ff <= duty_low_byte_ff;
            shadow_low_ff <= unit_control_reg_ff[`EBPWM_DLB_HI:`EBPWM_DLB_LO];
        end else if (reg_wr && reg_addr == `EBPWM_ADDR_DUTY_SH && !pwm_mode) begin
            duty_shadow_byte_ff <= reg_wdata;
        end
    end

    // ----------------------------------------
    // register reads
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `EBPWM_ADDR_CTRL: reg_rdata <= unit_control_reg_ff;
                `EBPWM_ADDR_DUTY_LO: reg_rdata <= duty_low_byte_ff;
                `EBPWM_ADDR_DUTY_SH: reg_rdata <= duty_shadow_byte_ff;
                `EBPWM_ADDR_PERIOD: reg_rdata <= period_limit_reg_ff;
                `EBPWM_ADDR_TIMER2: reg_rdata <= period_timer_count_ff;
                `EBPWM_ADDR_DEADBAND: reg_rdata <= deadband_delay_reg_ff;
                `EBPWM_ADDR_PRESCALE: reg_rdata <= {6'h00, prescale_sel_ff};
                `EBPWM_ADDR_CMP_LO: reg_rdata <= cmp_value_ff[7:0];
                `EBPWM_ADDR_CMP_HI: reg_rdata <= cmp_value_ff[15:8];
                `EBPWM_ADDR_TSEL: reg_rdata <= {7'h00, timer_sel_ff};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ----------------------------------------
    // q clock and prescaler
    // ----------------------------------------
    assign pre_last = pre_limit(act_pre_ff);
    assign inc_tick = (q_ff == `EBPWM_Q_PER_CYCLE) && (pre_cnt_ff == pre_last);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            q_ff <= 2'h0;
        end else begin
            q_ff <= q_ff + 2'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pre_cnt_ff <= 4'h0;
        end else if (q_ff == `EBPWM_Q_PER_CYCLE) begin
            pre_cnt_ff <= (pre_cnt_ff == pre_last) ? 4'h0 : pre_cnt_ff + 4'h1;
        end
    end

    // ----------------------------------------
    // period timer
    // ----------------------------------------
    assign period_match = (period_timer_count_ff == period_limit_reg_ff);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            period_timer_count_ff <= 8'h00;
        end else if (inc_tick) begin
            if (period_match) begin
                period_timer_count_ff <= 8'h00;
            end else begin
                period_timer_count_ff <= period_timer_count_ff + 8'h01;
            end
        end
    end

    // ----------------------------------------
    // buffered control load at period boundary; mode bits load at once while pwm is off and the new mode is not pwm
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            act_mode_ff <= 4'h0;
            act_cfg_ff <= 2'h0;
            act_pre_ff <= 2'h0;
            running_ff <= 1'b0;
        end else if (period_match && inc_tick) begin
            act_mode_ff <= unit_control_reg_ff[`EBPWM_MODE_HI:`EBPWM_MODE_LO];
            act_cfg_ff <= unit_control_reg_ff[`EBPWM_CFG_HI:`EBPWM_CFG_LO];
            act_pre_ff <= prescale_sel_ff;
            running_ff <= (unit_control_reg_ff[3:2] == 2'h3);
        end else if (!pwm_mode && unit_control_reg_ff[3:2] != 2'h3) begin
            act_mode_ff <= unit_control_reg_ff[`EBPWM_MODE_HI:`EBPWM_MODE_LO];
            running_ff <= 1'b0;
        end
    end

    assign nxt_delay = deadband_delay_reg_ff[6:0];

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            act_delay_ff <= 7'h00;
        end else if ((period_match && inc_tick) || duty_match) begin
            act_delay_ff <= nxt_delay;
        end
    end

    // ----------------------------------------
    // duty comparison and modulation
    // ----------------------------------------
    // sub-count is the q phase at prescale 1, the prescaler's low two bits at prescale 4 and its top two bits at prescale 16
    assign sub_bits = (act_pre_ff == 2'h0) ? q_ff :
        ((act_pre_ff == 2'h1) ? pre_cnt_ff[1:0] : pre_cnt_ff[3:2]);
    // last clock of a sub-count step
    assign step_end = (act_pre_ff == 2'h0) || ((q_ff == `EBPWM_Q_PER_CYCLE) &&
        ((act_pre_ff == 2'h1) || (pre_cnt_ff[1:0] == 2'h3)));
    // match one step ahead so the registered output drops after exactly duty steps
    assign pos_next = {1'b0, period_timer_count_ff, sub_bits} + 11'h001;
    assign duty_match = running_ff && !duty_done_ff && step_end &&
        ({1'b0, duty_shadow_byte_ff, shadow_low_ff} == pos_next);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pwm_ff <= 1'b0;
            duty_done_ff <= 1'b0;
        end else if (period_match && inc_tick) begin
            pwm_ff <= (unit_control_reg_ff[3:2] == 2'h3) && ({duty_low_byte_ff,
                unit_control_reg_ff[`EBPWM_DLB_HI:`EBPWM_DLB_LO]} != 10'h000);
            duty_done_ff <= 1'b0;
        end else if (duty_match) begin
            pwm_ff <= 1'b0;
            duty_done_ff <= 1'b1;
        end
    end

    // ----------------------------------------
    // compare special event
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cmp_hit_ff <= 1'b0;
        end else begin
            cmp_hit_ff <= (act_mode_ff == `EBPWM_MODE_SPECIAL) &&
                ((timer_sel_ff ? timer_three_count : timer_one_count) == cmp_value_ff);
        end
    end

    assign timer_one_reset = cmp_hit_ff && !timer_sel_ff;
    assign timer_three_reset = cmp_hit_ff && timer_sel_ff;

    // ----------------------------------------
    // dead-band legs and bridge steering
    // ----------------------------------------
    logic db_a;
    logic db_b;
    logic tcy_tick;
    logic half_mode;
    logic [3:0] raw;
    logic [3:0] inv;

    assign tcy_tick = (q_ff == `EBPWM_Q_PER_CYCLE);
    assign half_mode = (act_cfg_ff == EBPWM_CFG_HALF);

    ebpwm_deadband u_db_a (
        .clock(clock),
        .sys_rst(sys_rst),
        .tick(tcy_tick),
        .delay(act_delay_ff),
        .level_in(pwm_ff),
        .level_out(db_a)
    );

    ebpwm_deadband u_db_b (
        .clock(clock),
        .sys_rst(sys_rst),
        .tick(tcy_tick),
        .delay(act_delay_ff),
        .level_in(running_ff && !pwm_ff),
        .level_out(db_b)
    );

    always_comb begin
        raw = 4'h0;
        unique case (ebpwm_cfg_t'(act_cfg_ff))
            EBPWM_CFG_SINGLE: raw = {3'h0, pwm_ff};
            EBPWM_CFG_HALF: raw = {2'h0, db_b, db_a};
            EBPWM_CFG_FWD: raw = {pwm_ff, 2'h0, running_ff};
            EBPWM_CFG_REV: raw = {1'b0, running_ff, pwm_ff, 1'b0};
        endcase
    end

    // polarity: mode bits 1 and 0 invert pairs a/c and b/d
    assign inv = {act_mode_ff[0], act_mode_ff[1], act_mode_ff[0], act_mode_ff[1]};

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bridge_out_a <= 1'b0;
            bridge_out_b <= 1'b0;
            bridge_out_c <= 1'b0;
            bridge_out_d <= 1'b0;
            single_compare_out <= 1'b0;
        end else begin
            bridge_out_a <= running_ff && (raw[0] ^ inv[0]);
            bridge_out_b <= running_ff && (raw[1] ^ inv[1]);
            bridge_out_c <= running_ff && (raw[2] ^ inv[2]);
            bridge_out_d <= running_ff && (raw[3] ^ inv[3]);
            single_compare_out <= running_ff && (raw[0] ^ inv[0]);
        end
    end

    // pins owned by the unit; direction bits stay with software
    always_comb begin
        pin_owned = 4'h0;
        if (pwm_mode) begin
            if (act_cfg_ff[0]) begin
                pin_owned = 4'hf;
            end else if (half_mode) begin
                pin_owned = 4'h3;
            end else begin
                pin_owned = 4'h1;
            end
        end
    end
endmodule : ebpwm_core

// File: ebpwm_defines.svh
/*
 holds offsets, field positions, reset values and timing counts of the bridge pwm unit.
 assumes inclusion by bare name from the design files.
*/
`ifndef EBPWM_DEFINES_SVH
`define EBPWM_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define EBPWM_ADDR_CTRL 4'h0
`define EBPWM_ADDR_DUTY_LO 4'h1
`define EBPWM_ADDR_DUTY_SH 4'h2
`define EBPWM_ADDR_PERIOD 4'h3
`define EBPWM_ADDR_TIMER2 4'h4
`define EBPWM_ADDR_DEADBAND 4'h5
`define EBPWM_ADDR_PRESCALE 4'h6
`define EBPWM_ADDR_CMP_LO 4'h7
`define EBPWM_ADDR_CMP_HI 4'h8
`define EBPWM_ADDR_TSEL 4'h9

// ----------------------------------------
// field positions
// ----------------------------------------
`define EBPWM_CFG_HI 7
`define EBPWM_CFG_LO 6
`define EBPWM_DLB_HI 5
`define EBPWM_DLB_LO 4
`define EBPWM_MODE_HI 3
`define EBPWM_MODE_LO 0

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define EBPWM_RST_CTRL 8'h00
`define EBPWM_RST_PERIOD 8'hff
`define EBPWM_RST_BYTE 8'h00
`define EBPWM_MODE_SPECIAL 4'hb
`define EBPWM_Q_PER_CYCLE 2'h3

`endif

// File: ebpwm_pkg.sv
/*
 holds the types of the bridge pwm unit.
 assumes nothing beyond a systemverilog compiler.
*/
package ebpwm_pkg;
    typedef enum logic [1:0] {
        EBPWM_CFG_SINGLE = 2'h0,
        EBPWM_CFG_FWD = 2'h1,
        EBPWM_CFG_HALF = 2'h2,
        EBPWM_CFG_REV = 2'h3
    } ebpwm_cfg_t;
    typedef logic [9:0] ebpwm_duty_t;
endpackage : ebpwm_pkg

// File: ebpwm_deadband.sv
/*
 holds the dead-band delay of one half-bridge leg.
 assumes a one-cycle tick per instruction cycle on the same clock.
*/
`include "ebpwm_defines.svh"

module ebpwm_deadband (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic tick,
    input wire logic [6:0] delay,
    input wire logic level_in,
    output logic level_out
);
    import ebpwm_pkg::*;

    logic [6:0] cnt_ff;
    logic prev_ff;

    // ----------------------------------------
    // delay inactive-to-active edge only
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cnt_ff <= 7'h00;
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= level_in;
            if (!level_in) begin
                cnt_ff <= 7'h00;
            end else if (!prev_ff) begin
                cnt_ff <= delay;
            end else if (tick && cnt_ff != 7'h00) begin
                cnt_ff <= cnt_ff - 7'h01;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            level_out <= 1'b0;
        end else begin
            level_out <= level_in && (prev_ff ? (cnt_ff == 7'h00) : (delay == 7'h00));
        end
    end
endmodule : ebpwm_deadband

// File: ebpwm_core_chk.sv
/*
 port checker of the bridge pwm unit, bound to ebpwm_core.
 assumes one clock and a master that never raises both strobes at once.
*/
`include "ebpwm_defines.svh"

module ebpwm_core_chk (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [15:0] timer_one_count,
    input wire logic [15:0] timer_three_count,
    input wire logic timer_one_reset,
    input wire logic timer_three_reset,
    input wire logic single_compare_out,
    input wire logic bridge_out_a,
    input wire logic bridge_out_b,
    input wire logic bridge_out_c,
    input wire logic bridge_out_d,
    input wire logic [3:0] pin_owned
);
    logic [7:0] lim_ff;
    logic [15:0] cmp_ff;
    logic tsel_ff;
    logic armed_ff;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    // ----------------------------------------
    // written register copies
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            lim_ff <= `EBPWM_RST_PERIOD;
            cmp_ff <= 16'h0000;
            tsel_ff <= 1'b0;
            armed_ff <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == `EBPWM_ADDR_PERIOD) lim_ff <= reg_wdata;
            if (reg_addr == `EBPWM_ADDR_CMP_LO) cmp_ff[7:0] <= reg_wdata;
            if (reg_addr == `EBPWM_ADDR_CMP_HI) cmp_ff[15:8] <= reg_wdata;
            if (reg_addr == `EBPWM_ADDR_TSEL) tsel_ff <= reg_wdata[0];
            if (reg_addr == `EBPWM_ADDR_CTRL && reg_wdata[3:2] == 2'h3) armed_ff <= 1'b1;
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    out_mirror_a: assert property (single_compare_out == bridge_out_a)
        else $error("single output differs from bridge a");
    pin_map_a: assert property (pin_owned inside {4'h0, 4'h1, 4'h3, 4'hf})
        else $error("illegal pin ownership");
    rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data without read");
    limit_read_a: assert property (reg_rd && reg_addr == `EBPWM_ADDR_PERIOD |=> reg_rdata == lim_ff)
        else $error("period limit readback wrong");
    one_timer_a: assert property (!(timer_one_reset && timer_three_reset))
        else $error("both timers reset");
    t1_cause_a: assert property (timer_one_reset |-> !tsel_ff &&
        (timer_one_count == cmp_ff || $past(timer_one_count) == cmp_ff
        || $past(timer_one_count, 2) == cmp_ff)) else $error("timer one reset without match");
    t3_cause_a: assert property (timer_three_reset |-> tsel_ff &&
        (timer_three_count == cmp_ff || $past(timer_three_count) == cmp_ff
        || $past(timer_three_count, 2) == cmp_ff)) else $error("timer three reset without match");
    boot_idle_a: assert property (!armed_ff |->
        {bridge_out_a, bridge_out_b, bridge_out_c, bridge_out_d} == 4'h0)
        else $error("bridge active before pwm mode");
endmodule : ebpwm_core_chk

bind ebpwm_core ebpwm_core_chk ebpwm_core_chk_inst (.clock(clock), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .timer_one_count(timer_one_count),
    .timer_three_count(timer_three_count), .timer_one_reset(timer_one_reset),
    .timer_three_reset(timer_three_reset), .single_compare_out(single_compare_out),
    .bridge_out_a(bridge_out_a), .bridge_out_b(bridge_out_b), .bridge_out_c(bridge_out_c),
    .bridge_out_d(bridge_out_d), .pin_owned(pin_owned));

// File: ebpwm_driver_model.sv
/*
 switch driver model: measures high time and period of one gate line.
 assumes the gate is sampled on the unit clock; lengths latch at each rise.
*/
module ebpwm_driver_model (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic gate,
    output logic [15:0] hi_len,
    output logic [15:0] per_len
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] hi_acc;
    logic [15:0] per_acc;
    logic gate_q;
    always_ff @(posedge clock) begin
        gate_q <= gate;
        if (sys_rst) begin
            hi_acc <= 16'h0000;
            per_acc <= 16'h0000;
            hi_len <= 16'h0000;
            per_len <= 16'h0000;
        end else if (gate && !gate_q) begin
            hi_len <= hi_acc;
            per_len <= per_acc;
            hi_acc <= 16'h0001;
            per_acc <= 16'h0001;
        end else begin
            hi_acc <= hi_acc + {15'h0000, gate};
            per_acc <= per_acc + 16'h0001;
        end
    end
endmodule : ebpwm_driver_model

// File: enhanced_bridge_pwm_bench.sv
/*
 self-checking bench of the bridge pwm unit over its register port.
 assumes a 200 MHz clock and timers modelled here as free counters.
*/
`include "ebpwm_defines.svh"

module enhanced_bridge_pwm_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock;
    logic sys_rst;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic [15:0] t1 = 16'h0000;
    logic [15:0] t3 = 16'h0000;
    logic r1, r3, sco, ba, bb, bc, bd, gate;
    logic [3:0] pin_owned;
    logic [1:0] probe;
    logic [3:0] outs;
    logic tclr = 1'b0;
    logic [15:0] hi_len, per_len;
    int failures = 0, num_checks = 0, n1 = 0, n3 = 0, a1, a3;
    localparam logic [7:0] ctl [5] = '{8'h2c, 8'hac, 8'h6c, 8'hec, 8'h6f};
    localparam logic [3:0] own [5] = '{4'h1, 4'h3, 4'hf, 4'hf, 4'hf};
    localparam logic [1:0] prb [5] = '{2'h0, 2'h1, 2'h3, 2'h1, 2'h3};
    localparam logic [15:0] hil [5] = '{16'h0012, 16'h0016, 16'h0012, 16'h0012, 16'h0016};
    localparam logic [3:0] msk [5] = '{4'he, 4'hc, 4'h7, 4'hd, 4'h7};
    localparam logic [3:0] val [5] = '{4'h0, 4'h0, 4'h1, 4'h4, 4'h6};
    assign outs = {bd, bc, bb, ba};
    assign gate = outs[probe];

    ebpwm_core ebpwm_core_inst (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .timer_one_count(t1), .timer_three_count(t3), .timer_one_reset(r1),
        .timer_three_reset(r3), .single_compare_out(sco), .bridge_out_a(ba),
        .bridge_out_b(bb), .bridge_out_c(bc), .bridge_out_d(bd), .pin_owned(pin_owned));
    ebpwm_driver_model ebpwm_driver_model_inst (.clock(clock), .sys_rst(sys_rst),
        .gate(gate), .hi_len(hi_len), .per_len(per_len));

    // ----------------------------------------
    // clock, timers, tasks
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        t1 <= (r1 || tclr) ? 16'h0000 : t1 + 16'h0001;
        t3 <= (r3 || tclr) ? 16'h0000 : t3 + 16'h0001;
        n1 <= n1 + int'(r1);
        n3 <= n3 + int'(r3);
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask : rd
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
    endtask : wt
    task automatic hold(input logic [3:0] exp, input logic [3:0] m);
        int bad;
        bad = 0;
        repeat (40) begin
            @(posedge clock);
            #1 if (({bd, bc, bb, ba} & m) !== exp) bad++;
        end
        chk(16'(bad), 16'h0000);
    endtask : hold
    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done
    task automatic close_out;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        close_out();
    end
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        probe = 2'h0;
        sys_rst = 1'b1;
        wt(16);
        sys_rst <= 1'b0;
        rd(`EBPWM_ADDR_CTRL, `EBPWM_RST_CTRL);
        rd(`EBPWM_ADDR_PERIOD, 8'hff);
        rd(4'hf, 8'h00);
        chk({12'h000, pin_owned}, 16'h0000);
        done("reset");
        wr(`EBPWM_ADDR_PERIOD, 8'h09);
        wr(`EBPWM_ADDR_PRESCALE, 8'h00);
        wr(`EBPWM_ADDR_DUTY_LO, 8'h04);
        wr(`EBPWM_ADDR_CTRL, 8'h2c);
        wt(160);
        chk(per_len, 16'h0028);
        chk(hi_len, 16'h0012);
        rd(`EBPWM_ADDR_DUTY_SH, 8'h04);
        wr(`EBPWM_ADDR_DUTY_SH, 8'h55);
        rd(`EBPWM_ADDR_DUTY_SH, 8'h04);
        wr(`EBPWM_ADDR_PRESCALE, 8'h01);
        wt(640);
        chk(per_len, 16'h00a0);
        chk(hi_len, 16'h0048);
        wr(`EBPWM_ADDR_PRESCALE, 8'h02);
        wt(1600);
        chk(per_len, 16'h0280);
        chk(hi_len, 16'h0120);
        wr(`EBPWM_ADDR_PRESCALE, 8'h00);
        wt(700);
        done("period");
        for (int i = 0; i < 5; i++) begin
            probe <= prb[i];
            wr(`EBPWM_ADDR_CTRL, ctl[i]);
            wt(160);
            chk({12'h000, pin_owned}, {12'h000, own[i]});
            chk(hi_len, hil[i]);
            hold(val[i], msk[i]);
        end
        done("modes");
        probe <= 2'h0;
        wr(`EBPWM_ADDR_DUTY_LO, 8'h00);
        wr(`EBPWM_ADDR_CTRL, 8'h0c);
        wt(100);
        hold(4'h0, 4'h1);
        wr(`EBPWM_ADDR_DUTY_LO, 8'h0a);
        wt(100);
        hold(4'h1, 4'h1);
        wr(`EBPWM_ADDR_DUTY_LO, 8'h09);
        wr(`EBPWM_ADDR_CTRL, 8'h3c);
        wt(160);
        chk(hi_len, 16'h0027);
        chk(per_len, 16'h0028);
        wr(`EBPWM_ADDR_DUTY_LO, 8'h04);
        wr(`EBPWM_ADDR_DEADBAND, 8'h7f);
        wr(`EBPWM_ADDR_CTRL, 8'hac);
        wt(160);
        hold(4'h0, 4'h3);
        done("duty");
        wr(`EBPWM_ADDR_CTRL, 8'h00);
        wr(`EBPWM_ADDR_CMP_LO, 8'h14);
        wr(`EBPWM_ADDR_CMP_HI, 8'h00);
        wt(50);
        for (int s = 0; s < 2; s++) begin
            wr(`EBPWM_ADDR_CTRL, 8'h00);
            wr(`EBPWM_ADDR_TSEL, 8'(s));
            wr(`EBPWM_ADDR_CTRL, 8'(`EBPWM_MODE_SPECIAL));
            tclr <= 1'b1;
            wt(1);
            tclr <= 1'b0;
            a1 = n1;
            a3 = n3;
            wt(300);
            chk(16'((s == 0 ? n1 - a1 : n3 - a3) >= 8), 16'h0001);
            chk(16'(s == 0 ? n3 - a3 : n1 - a1), 16'h0000);
        end
        done("special event");
        close_out();
    end
endmodule : enhanced_bridge_pwm_bench
